// file: utc_defs.svh
`ifndef UTC_DEFS_SVH
`define UTC_DEFS_SVH

// register addresses on the special-function register port
`define UTC_XCN_ADDR      8'hd7
`define UTC_ADR_ADDR      8'h96
`define UTC_DAT_ADDR      8'h97

// transceiver control field positions
`define UTC_XCN_PULL_BIT  7
`define UTC_XCN_ENA_BIT   6
`define UTC_XCN_SPEED_BIT 5
`define UTC_XCN_TEST_LSB  3
`define UTC_XCN_DIFF_BIT  2
`define UTC_XCN_DP_BIT    1
`define UTC_XCN_DN_BIT    0

// indirect address port field positions
`define UTC_ADR_BUSY_BIT  7
`define UTC_ADR_AUTO_BIT  6
`define UTC_ADR_SEL_MSB   5

// reset values
`define UTC_XCN_RESET     8'h00
`define UTC_ADR_RESET     8'h00
`define UTC_DAT_RESET     8'h00

// indirect address of the endpoint index register
`define UTC_INDEX_ADDR    6'h0e

// synchroniser bit positions
`define UTC_SYN_DP        0
`define UTC_SYN_DN        1
`define UTC_SYN_DIFF      2
`define UTC_SYN_VBUS      3
`define UTC_SYN_W         4

`endif

// file: utc_pkg.sv
package utc_pkg;

  // line test modes
  typedef enum logic [1:0] {
    UTC_TEST_NORMAL = 2'h0,
    UTC_TEST_DIFF1  = 2'h1,
    UTC_TEST_DIFF0  = 2'h2,
    UTC_TEST_SE0    = 2'h3
  } utc_test_e;

  // indirect access sequencer, gray coded from idle
  typedef enum logic [1:0] {
    UTC_IND_IDLE = 2'h0,
    UTC_IND_RD   = 2'h1,
    UTC_IND_WR   = 2'h2
  } utc_ind_e;

  typedef logic [7:0] utc_byte_t;
  typedef logic [5:0] utc_sel_t;

  typedef struct packed {
    logic      pullup_enable;
    logic      transceiver_enable;
    logic      speed_full;
    utc_test_e line_test_mode;
    logic      busy;
    logic      auto_read_enable;
    utc_sel_t  indirect_register_selector;
    utc_byte_t indirect_data;
    utc_ind_e  ind_state;
    utc_byte_t endpoint_index;
    utc_byte_t sfr_rdata;
    logic      ind_rd;
    logic      ind_wr;
    utc_byte_t ind_wdata;
    logic      dp_out;
    logic      dp_oe_n;
    logic      dn_out;
    logic      dn_oe_n;
    logic      pullup_dp;
    logic      pullup_dn;
    logic      xcvr_active;
  } utc_state_s;

endpackage

// file: utc_sync_if.sv
`timescale 1ns/100ps
`include "utc_defs.svh"
interface utc_sync_if;
  logic [`UTC_SYN_W-1:0] raw;
  logic [`UTC_SYN_W-1:0] synced;

  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface

// file: utc_sync.sv
`timescale 1ns/100ps
`include "utc_defs.svh"
module utc_sync
(
  input  wire logic sys_clk,
  input  wire logic arst_n,
  utc_sync_if.dst   sync
);
  typedef struct packed {
    logic [`UTC_SYN_W-1:0] stage1;
    logic [`UTC_SYN_W-1:0] stage2;
  } utc_sync_s;

  utc_sync_s sync_ff;
  utc_sync_s nxt_sync;

  // stage1 feeds only stage2, so metastability never reaches logic
  always_comb
  begin
    nxt_sync.stage1 = sync.raw;
    nxt_sync.stage2 = sync_ff.stage1;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      sync_ff <= '0;
    else
      sync_ff <= nxt_sync;
  end

  assign sync.synced = sync_ff.stage2;
endmodule // utc_sync

// file: utc_xcvr_access.sv
`timescale 1ns/100ps
`include "utc_defs.svh"
// Functional notes
// - speed 0 puts the enabled pull-up on D- (low speed), 1 on D+ (full).
// - test mode 00 leaves both lines to the normal transceiver path.
// - test 01 forces D+ high D- low, 10 D+ low D- high, 11 both low.
// - with the transceiver enabled a status bit shows the differential state.
// - a status bit shows the present level of the D+ pin.
// - a status bit shows the present level of the D- pin.
// - internal registers are reached only via an address port and data port.
// - software writes the index register first; accesses then go to that endpoint.
// - transceiver enable 0 suspends the transceiver, 1 runs it normally.
// - the pull-up connects only when enabled and VBUS is present.
// - an indirect read sets busy, which clears once the data port is valid.
// - with auto-read set, reading the data port starts the next read.
module utc_xcvr_access
(
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // special-function register port
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire utc_pkg::utc_byte_t sfr_wdata,
  output      utc_pkg::utc_byte_t sfr_rdata,
  // indirect register path into the controller core
  output      utc_pkg::utc_sel_t ind_addr,
  output      utc_pkg::utc_byte_t ind_endpoint,
  output      logic              ind_rd,
  output      logic              ind_wr,
  output      utc_pkg::utc_byte_t ind_wdata,
  input  wire utc_pkg::utc_byte_t ind_rdata,
  input  wire logic              ind_ack,
  // serial engine drive in normal mode
  input  wire logic              sie_dp,
  input  wire logic              sie_dn,
  input  wire logic              sie_oe,
  // bus pins and analog receiver
  input  wire logic              dp_in,
  input  wire logic              dn_in,
  input  wire logic              diff_rx_in,
  input  wire logic              vbus_in,
  output      logic              dp_out,
  output      logic              dp_oe_n,
  output      logic              dn_out,
  output      logic              dn_oe_n,
  output      logic              pullup_dp,
  output      logic              pullup_dn,
  output      logic              xcvr_active
);
  import utc_pkg::*;

  utc_state_s st_ff;
  utc_state_s nxt_st;
  utc_sync_if sync_bus ();

  logic       wr_xcn;
  logic       wr_adr;
  logic       wr_dat;
  logic       rd_dat;
  logic       vbus_s;
  logic       diff_s;
  utc_byte_t  xcn_view;
  utc_byte_t  adr_view;

  // pins and the receiver come from outside the clock domain
  assign sync_bus.raw = {vbus_in, diff_rx_in, dn_in, dp_in};

  utc_sync u_sync
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .sync    (sync_bus)
  );

  // strobes decoded from the register port
  assign wr_xcn = sfr_wr && (sfr_addr == `UTC_XCN_ADDR);
  assign wr_adr = sfr_wr && (sfr_addr == `UTC_ADR_ADDR);
  assign wr_dat = sfr_wr && (sfr_addr == `UTC_DAT_ADDR);
  assign rd_dat = sfr_rd && (sfr_addr == `UTC_DAT_ADDR);

  assign vbus_s = sync_bus.synced[`UTC_SYN_VBUS];
  // receiver output is meaningless in suspend, so it reads as zero
  assign diff_s = sync_bus.synced[`UTC_SYN_DIFF]
                  && st_ff.transceiver_enable;

  // read views of the two direct registers
  always_comb
  begin
    xcn_view = `UTC_XCN_RESET;
    xcn_view[`UTC_XCN_PULL_BIT]  = st_ff.pullup_enable;
    xcn_view[`UTC_XCN_ENA_BIT]   = st_ff.transceiver_enable;
    xcn_view[`UTC_XCN_SPEED_BIT] = st_ff.speed_full;
    xcn_view[`UTC_XCN_TEST_LSB +: 2] = st_ff.line_test_mode;
    xcn_view[`UTC_XCN_DIFF_BIT]  = diff_s;
    xcn_view[`UTC_XCN_DP_BIT]    = sync_bus.synced[`UTC_SYN_DP];
    xcn_view[`UTC_XCN_DN_BIT]    = sync_bus.synced[`UTC_SYN_DN];
    adr_view = `UTC_ADR_RESET;
    adr_view[`UTC_ADR_BUSY_BIT]  = st_ff.busy;
    adr_view[`UTC_ADR_AUTO_BIT]  = st_ff.auto_read_enable;
    adr_view[`UTC_ADR_SEL_MSB:0] = st_ff.indirect_register_selector;
  end

  // next state of the whole block
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ind_rd = 1'b0;
    nxt_st.ind_wr = 1'b0;

    // transceiver control, writable bits only
    if (wr_xcn)
    begin
      nxt_st.pullup_enable      = sfr_wdata[`UTC_XCN_PULL_BIT];
      nxt_st.transceiver_enable = sfr_wdata[`UTC_XCN_ENA_BIT];
      nxt_st.speed_full         = sfr_wdata[`UTC_XCN_SPEED_BIT];
      nxt_st.line_test_mode =
        utc_test_e'(sfr_wdata[`UTC_XCN_TEST_LSB +: 2]);
    end

    // indirect sequencer; new requests are ignored while busy
    case (st_ff.ind_state)
      UTC_IND_IDLE:
      begin
        if (wr_adr)
        begin
          nxt_st.auto_read_enable = sfr_wdata[`UTC_ADR_AUTO_BIT];
          nxt_st.indirect_register_selector =
            sfr_wdata[`UTC_ADR_SEL_MSB:0];
          if (sfr_wdata[`UTC_ADR_BUSY_BIT])
          begin
            nxt_st.busy      = 1'b1;
            nxt_st.ind_rd    = 1'b1;
            nxt_st.ind_state = UTC_IND_RD;
          end
        end
        else if (wr_dat)
        begin
          nxt_st.busy      = 1'b1;
          nxt_st.ind_wr    = 1'b1;
          nxt_st.ind_wdata = sfr_wdata;
          nxt_st.ind_state = UTC_IND_WR;
          // snoop the index so per-endpoint accesses are steered
          if (st_ff.indirect_register_selector == `UTC_INDEX_ADDR)
            nxt_st.endpoint_index = sfr_wdata;
        end
        else if (rd_dat && st_ff.auto_read_enable)
        begin
          nxt_st.busy      = 1'b1;
          nxt_st.ind_rd    = 1'b1;
          nxt_st.ind_state = UTC_IND_RD;
        end
      end
      UTC_IND_RD:
      begin
        if (ind_ack)
        begin
          nxt_st.indirect_data = ind_rdata;
          nxt_st.busy          = 1'b0;
          nxt_st.ind_state     = UTC_IND_IDLE;
        end
      end
      UTC_IND_WR:
      begin
        if (ind_ack)
        begin
          nxt_st.busy      = 1'b0;
          nxt_st.ind_state = UTC_IND_IDLE;
        end
      end
      default:
      begin
        nxt_st.busy      = 1'b0;
        nxt_st.ind_state = UTC_IND_IDLE;
      end
    endcase

    // read data is registered, valid the cycle after the strobe
    if (sfr_rd)
    begin
      case (sfr_addr)
        `UTC_XCN_ADDR: nxt_st.sfr_rdata = xcn_view;
        `UTC_ADR_ADDR: nxt_st.sfr_rdata = adr_view;
        `UTC_DAT_ADDR: nxt_st.sfr_rdata = st_ff.indirect_data;
        default:       nxt_st.sfr_rdata = 8'h00;
      endcase
    end

    // suspend when the enable is clear
    nxt_st.xcvr_active = nxt_st.transceiver_enable;

    // pull-up placement follows speed, gated by vbus
    nxt_st.pullup_dp = nxt_st.pullup_enable && vbus_s
                       && nxt_st.speed_full;
    nxt_st.pullup_dn = nxt_st.pullup_enable && vbus_s
                       && !nxt_st.speed_full;

    // line drive: test modes override the serial engine
    case (nxt_st.line_test_mode)
      UTC_TEST_DIFF1:
      begin
        nxt_st.dp_out = 1'b1;
        nxt_st.dn_out = 1'b0;
      end
      UTC_TEST_DIFF0:
      begin
        nxt_st.dp_out = 1'b0;
        nxt_st.dn_out = 1'b1;
      end
      UTC_TEST_SE0:
      begin
        nxt_st.dp_out = 1'b0;
        nxt_st.dn_out = 1'b0;
      end
      default:
      begin
        nxt_st.dp_out = sie_dp;
        nxt_st.dn_out = sie_dn;
      end
    endcase
    if (nxt_st.line_test_mode != UTC_TEST_NORMAL)
    begin
      nxt_st.dp_oe_n = 1'b0;
      nxt_st.dn_oe_n = 1'b0;
    end
    else
    begin
      // in normal mode a suspended transceiver never drives the bus
      nxt_st.dp_oe_n = !(sie_oe && nxt_st.transceiver_enable);
      nxt_st.dn_oe_n = !(sie_oe && nxt_st.transceiver_enable);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff                <= '0;
      st_ff.line_test_mode <= UTC_TEST_NORMAL;
      st_ff.ind_state      <= UTC_IND_IDLE;
      st_ff.dp_oe_n        <= 1'b1;
      st_ff.dn_oe_n        <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // outputs straight from the state register
  assign sfr_rdata    = st_ff.sfr_rdata;
  assign ind_addr     = st_ff.indirect_register_selector;
  assign ind_endpoint = st_ff.endpoint_index;
  assign ind_rd       = st_ff.ind_rd;
  assign ind_wr       = st_ff.ind_wr;
  assign ind_wdata    = st_ff.ind_wdata;
  assign dp_out       = st_ff.dp_out;
  assign dp_oe_n      = st_ff.dp_oe_n;
  assign dn_out       = st_ff.dn_out;
  assign dn_oe_n      = st_ff.dn_oe_n;
  assign pullup_dp    = st_ff.pullup_dp;
  assign pullup_dn    = st_ff.pullup_dn;
  assign xcvr_active  = st_ff.xcvr_active;
endmodule // utc_xcvr_access

// file: utc_host_model.sv
`timescale 1ns/100ps
// host end of the cable: pull-downs on both lines, optional drive
module utc_host_model
(
  input  wire logic dp_out,
  input  wire logic dp_oe_n,
  input  wire logic dn_out,
  input  wire logic dn_oe_n,
  input  wire logic pullup_dp,
  input  wire logic pullup_dn,
  input  wire logic host_en,
  input  wire logic host_dp,
  input  wire logic host_dn,
  output logic      dp_in,
  output logic      dn_in,
  output logic      diff_rx_in
);
  // device drive wins, then host drive; an undriven line falls unless a pull-up holds it
  assign dp_in = !dp_oe_n ? dp_out : host_en ? host_dp : pullup_dp;
  assign dn_in = !dn_oe_n ? dn_out : host_en ? host_dn : pullup_dn;
  // se0 and se1 read as differential zero
  assign diff_rx_in = dp_in & ~dn_in;
endmodule // utc_host_model

// file: utc_monitor.sv
`timescale 1ns/100ps
module utc_monitor
(
  input wire logic               sys_clk,
  input wire logic               arst_n,
  input wire logic [7:0]         sfr_addr,
  input wire logic               sfr_wr,
  input wire logic               sfr_rd,
  input wire utc_pkg::utc_byte_t sfr_wdata,
  input wire utc_pkg::utc_byte_t sfr_rdata,
  input wire utc_pkg::utc_sel_t  ind_addr,
  input wire utc_pkg::utc_byte_t ind_endpoint,
  input wire logic               ind_rd,
  input wire logic               ind_wr,
  input wire utc_pkg::utc_byte_t ind_wdata,
  input wire logic               ind_ack,
  input wire logic               dp_in,
  input wire logic               dn_in,
  input wire logic               dp_out,
  input wire logic               dp_oe_n,
  input wire logic               dn_out,
  input wire logic               dn_oe_n,
  input wire logic               pullup_dp,
  input wire logic               pullup_dn,
  input wire logic               xcvr_active
);
  import utc_pkg::*;
  logic       pend_ff;
  logic       auto_ff;
  logic [2:0] age_ff;
  wire xcn_wr = sfr_wr && sfr_addr == 8'hd7;
  wire adr_wr = sfr_wr && sfr_addr == 8'h96;
  wire dat_wr = sfr_wr && sfr_addr == 8'h97;
  wire idle   = !pend_ff && !ind_rd && !ind_wr;
  // busy mirror from the ports; age keeps status checks off the sync reset
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
    begin
      pend_ff <= 1'b0;
      auto_ff <= 1'b0;
      age_ff  <= 3'h0;
    end
    else
    begin
      pend_ff <= (ind_rd || ind_wr) ? 1'b1 : ind_ack ? 1'b0 : pend_ff;
      auto_ff <= (adr_wr && idle) ? sfr_wdata[6] : auto_ff;
      age_ff  <= (age_ff == 3'h4) ? age_ff : age_ff + 3'h1;
    end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_diff1_force: assert property (
    xcn_wr && sfr_wdata[4:3] == 2'h1 |=>
    dp_out && !dn_out && !dp_oe_n && !dn_oe_n) else $error("diff1 force");
  a_se0_force: assert property (
    xcn_wr && sfr_wdata[4:3] == 2'h3 |=>
    !dp_out && !dn_out && !dp_oe_n && !dn_oe_n) else $error("se0 force");
  a_normal_float: assert property (
    xcn_wr && !sfr_wdata[6] && sfr_wdata[4:3] == 2'h0 |=>
    dp_oe_n && dn_oe_n) else $error("lines driven");
  a_xcvr_enable: assert property (
    xcn_wr |=> xcvr_active == $past(sfr_wdata[6])) else $error("enable");
  a_pullup_side: assert property (
    xcn_wr |=> !(pullup_dp && !$past(sfr_wdata[5])) &&
    !(pullup_dn && $past(sfr_wdata[5]))) else $error("pull-up side");
  a_read_start: assert property (
    adr_wr && sfr_wdata[7] && idle |=> ind_rd &&
    ind_addr == $past(sfr_wdata[5:0]) ##1 !ind_rd) else $error("read start");
  a_write_start: assert property (
    dat_wr && idle |=> ind_wr && ind_wdata == $past(sfr_wdata))
    else $error("write start");
  a_index_route: assert property (
    dat_wr && idle && ind_addr == 6'h0e |=>
    ind_endpoint == $past(sfr_wdata)) else $error("index");
  a_auto_next: assert property (
    sfr_rd && sfr_addr == 8'h97 && idle && auto_ff |=> ind_rd)
    else $error("auto read");
  a_line_status: assert property (
    sfr_rd && sfr_addr == 8'hd7 && age_ff == 3'h4 && $stable(dp_in) &&
    $stable(dn_in) && $past(dp_in, 2) == dp_in && $past(dn_in, 2) == dn_in
    |=> sfr_rdata[1:0] == {$past(dp_in), $past(dn_in)}) else $error("line");

  c_read: cover property (adr_wr && sfr_wdata[7] && idle);
  c_ack: cover property (ind_ack);
  c_se0: cover property (xcn_wr && sfr_wdata[4:3] == 2'h3);
endmodule // utc_monitor

bind utc_xcvr_access utc_monitor u_mon (.sys_clk, .arst_n, .sfr_addr,
  .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .ind_addr, .ind_endpoint,
  .ind_rd, .ind_wr, .ind_wdata, .ind_ack, .dp_in, .dn_in, .dp_out,
  .dp_oe_n, .dn_out, .dn_oe_n, .pullup_dp, .pullup_dn, .xcvr_active);

// file: utc_xcvr_access_tb.sv
`timescale 1ns/100ps
module utc_xcvr_access_tb;
  import utc_pkg::*;
  logic       sys_clk = 0, arst_n = 0, sfr_wr = 0, sfr_rd = 0, ind_ack = 0;
  logic       sie_dp = 0, sie_dn = 0, sie_oe = 0, vbus_in = 0, rd_seen = 0;
  logic       host_en = 0, host_dp = 0, host_dn = 0, en, r, ind_rd, ind_wr;
  logic       dp_in, dn_in, diff_rx_in, dp_out, dn_out, dp_oe_n, dn_oe_n;
  logic       pullup_dp, pullup_dn, xcvr_active;
  logic [1:0] m, lp, oe, h;
  logic [2:0] ack_cnt = 0, k;
  logic [7:0] sfr_addr = 0, core_mem [64];
  utc_byte_t  sfr_wdata = 0, ind_rdata = 0, sfr_rdata, ind_wdata, d;
  utc_byte_t  ind_endpoint, exp_q[$];
  utc_sel_t   ind_addr, s;
  int         n_errors = 0, tests_run = 0;

  utc_xcvr_access dut (.sys_clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .ind_addr, .ind_endpoint, .ind_rd, .ind_wr,
    .ind_wdata, .ind_rdata, .ind_ack, .sie_dp, .sie_dn, .sie_oe, .dp_in,
    .dn_in, .diff_rx_in, .vbus_in, .dp_out, .dp_oe_n, .dn_out, .dn_oe_n,
    .pullup_dp, .pullup_dn, .xcvr_active);
  utc_host_model host (.dp_out, .dp_oe_n, .dn_out, .dn_oe_n, .pullup_dp,
    .pullup_dn, .host_en, .host_dp, .host_dn, .dp_in, .dn_in, .diff_rx_in);

  always #12.5 sys_clk = ~sys_clk;

  // core side with a slow ack of 4..7 cycles; usb clock taken as running
  always @(posedge sys_clk)
  begin
    ind_rdata <= core_mem[ind_addr];
    if (ind_wr) core_mem[ind_addr] <= ind_wdata;
    ind_ack <= (ack_cnt == 3'h1);
    if (ind_rd || ind_wr) ack_cnt <= 3'(4 + $urandom % 4);
    else if (ack_cnt != 3'h0) ack_cnt <= ack_cnt - 3'h1;
  end

  // read data lands one cycle after the strobe and is matched in order
  always @(posedge sys_clk)
  begin
    if (rd_seen) chk(sfr_rdata, exp_q.pop_front());
    rd_seen <= sfr_rd;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr    <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
  endtask

  // bounded wait for the core ack, then let busy drop
  task automatic wait_idle;
    int n;
    n = 0;
    while (ind_ack !== 1'b1 && n < 40)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 40) n_errors++;
    tick(2);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence: reset, pins, pull-ups, indirect path, auto-read
  initial
  begin
    void'($urandom(32'hf0c3));
    tick(20);
    arst_n <= 1'b1;
    chk({3'h0, dp_oe_n, dn_oe_n, pullup_dp, pullup_dn, xcvr_active}, 8'h18);
    for (int i = 0; i < 3; i++) rd(8'h94 + 8'(i), 8'h00);
    rd(8'hd7, 8'h00);
    $display("reset test done");
    sie_oe <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      {en, m} = 3'(i);
      r = 1'($urandom);
      sie_dp <= r;
      sie_dn <= ~r;
      wr(8'hd7, {1'b0, en, 1'b0, m, 3'h0});
      tick(4);
      lp = (m == 2'h0) ? (en ? {r, ~r} : 2'h0) : {m == 2'h1, m == 2'h2};
      oe = (m == 2'h0 && !en) ? 2'h3 : 2'h0;
      chk({4'h0, dp_oe_n, dn_oe_n, dp_in, dn_in}, {4'h0, oe, lp});
      rd(8'hd7, {1'b0, en, 1'b0, m, en & lp[1] & ~lp[0], lp});
    end
    $display("line test done");
    sie_oe  <= 1'b0;
    host_en <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      k = 3'(i);
      h = 2'($urandom);
      vbus_in <= k[0];
      host_dp <= h[1];
      host_dn <= h[0];
      wr(8'hd7, {k[2], 1'b1, k[1], 5'h0});
      tick(5);
      chk({5'h0, xcvr_active, pullup_dp, pullup_dn},
        {5'h0, 1'b1, &k, k[2] & k[0] & ~k[1]});
      rd(8'hd7, {k[2], 1'b1, k[1], 2'h0, h[1] & ~h[0], h});
    end
    host_en <= 1'b0;
    $display("pull-up test done");
    wr(8'h96, 8'h0e);
    d = 8'($urandom);
    wr(8'h97, d);
    wait_idle;
    chk(ind_endpoint, d);
    for (int i = 0; i < 3; i++)
    begin
      s = 6'($urandom % 14);
      d = 8'($urandom);
      wr(8'h96, {2'h0, s});
      wr(8'h97, d);
      wait_idle;
      wr(8'h96, {2'h2, s});
      rd(8'h96, {2'h2, s});
      wr(8'h96, 8'h3f);
      wait_idle;
      rd(8'h96, {2'h0, s});
      rd(8'h97, d);
    end
    $display("indirect test done");
    wr(8'h96, {2'h3, s});
    wait_idle;
    rd(8'h97, d);
    rd(8'h96, {2'h3, s});
    wait_idle;
    rd(8'h97, d);
    wait_idle;
    $display("auto-read test done");
    tick(3);
    report_and_stop;
  end

  // watchdog sized well past the few hundred cycles the tests need
  initial
  begin
    #(25 * 4000);
    n_errors++;
    report_and_stop;
  end
endmodule // utc_xcvr_access_tb
